// ===== pkg/xdc_map.svh
// register offsets, field positions and reset values of the external dma channel sequencer
`ifndef XDC_MAP_SVH
`define XDC_MAP_SVH
`define XDC_OFS_SRC      3'h0
`define XDC_OFS_DST      3'h1
`define XDC_OFS_CNT      3'h2
`define XDC_OFS_MODE     3'h3
`define XDC_OFS_ACTL     3'h4
`define XDC_M_EN         0
`define XDC_M_BURST      1
`define XDC_M_EXT        2
`define XDC_M_BLOCK      3
`define XDC_M_DSIZE      4
`define XDC_M_GIVEUP     5
`define XDC_M_IE         6
`define XDC_M_FLAG       7
`define XDC_M_BERR       8
`define XDC_A_SMODE      1:0
`define XDC_A_DMODE      3:2
`define XDC_A_SREP       8:4
`define XDC_A_DREP       13:9
`define XDC_A_SRIE       14
`define XDC_A_DRIE       15
`define XDC_RST_ADDR     24'h000000
`define XDC_RST_CNT      24'h000000
`define XDC_RST_CFG      6'h00
`define XDC_RST_ACTL     16'h0000
`define XDC_BLK_FULL     9'h100
`endif

// ===== pkg/xdc_pkg.sv
// types shared by the external dma channel sequencer
package xdc_pkg;
    typedef enum logic [3:0] {
        XDC_IDLE = 4'b0001,
        XDC_RD   = 4'b0010,
        XDC_WR   = 4'b0100,
        XDC_REL  = 4'b1000
    } xdc_state_t;
    typedef logic [23:0] xdc_addr_t;
endpackage

// ===== hw/xdc_channel.sv
// one external-bus dma channel: bus modes, transfer modes, address and count update, avalon registers
`timescale 1ns/100ps
`include "xdc_map.svh"
module xdc_channel import xdc_pkg::*; (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        ext_req_i,
    output logic             req_ack_o,
    output logic             xfer_end_o,
    input  wire logic        hi_chan_req_i,
    input  wire logic        other_bus_req_i,
    input  wire logic        nmi_i,
    output logic             bus_own_o,
    output logic      [23:0] mem_addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [15:0] mem_wdata_o,
    input  wire logic [15:0] mem_rdata_i,
    input  wire logic        mem_ready_i,
    output logic             irq_o
);
    // byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // next address with repeat-area wrap; bit 24 flags an overflow
    function automatic logic [24:0] adv(input xdc_addr_t a, input logic [1:0] md, input logic [4:0] rep,
                                        input logic word);
        logic [23:0] step;
        logic [23:0] msk;
        logic [23:0] nxt;
        logic [24:0] lo_sum;
        logic        ovf;
        step   = word ? 24'h000002 : 24'h000001;
        // settings above 23 are prohibited; treat them as no repeat area
        msk    = (rep == 5'h00 || rep > 5'h17) ? 24'hffffff : ((24'h000001 << rep) - 24'h000001);
        lo_sum = {1'b0, a & msk} + {1'b0, step};
        ovf    = (msk != 24'hffffff) && (md[0] ? ((a & msk) < step) : (lo_sum > {1'b0, msk}));
        nxt    = md[1] ? (md[0] ? a - step : a + step) : a;
        return {ovf & md[1], (a & ~msk) | (nxt & msk)};
    endfunction

    xdc_state_t  st_q, st_d;          // sequencer state
    xdc_addr_t   src_q;               // source address
    xdc_addr_t   dst_q;               // destination address
    logic [23:0] cnt_q;               // transfer count
    logic [5:0]  cfg_q;               // mode bits 6..1
    logic        en_q;                // channel enable
    logic        flag_q;              // repeat overflow flag
    logic        berr_q;              // block aborted flag
    logic [15:0] actl_q;              // address control
    logic        halt_q;              // disable requested while busy
    logic        ovf_q;               // overflow waiting for unit end
    logic        in_unit_q;           // a unit (block) is in progress
    logic [8:0]  blk_left_q;          // transfers left in current unit
    logic        ack_q;               // request-accepted pulse
    logic [15:0] data_q;              // read data held for write cycle
    logic [31:0] rdata_q;             // read snapshot
    logic        rd_done_q;           // read answer cycle

    // register decode
    wire [2:0]  reg_idx  = avs_address_i[4:2];
    wire        wr_src   = ce_i & avs_write_i & (reg_idx == `XDC_OFS_SRC);
    wire        wr_dst   = ce_i & avs_write_i & (reg_idx == `XDC_OFS_DST);
    wire        wr_cnt   = ce_i & avs_write_i & (reg_idx == `XDC_OFS_CNT);
    wire        wr_mode  = ce_i & avs_write_i & (reg_idx == `XDC_OFS_MODE);
    wire        wr_actl  = ce_i & avs_write_i & (reg_idx == `XDC_OFS_ACTL);
    wire [31:0] mode_rd  = {23'h0, berr_q, flag_q, cfg_q, en_q};
    wire [31:0] mode_wv  = mrg(mode_rd, avs_writedata_i, avs_byteenable_i);
    wire [31:0] rd_mux   = (reg_idx == `XDC_OFS_SRC)  ? {8'h00, src_q}  :
                           (reg_idx == `XDC_OFS_DST)  ? {8'h00, dst_q}  :
                           (reg_idx == `XDC_OFS_CNT)  ? {8'h00, cnt_q}  :
                           (reg_idx == `XDC_OFS_MODE) ? mode_rd         :
                           (reg_idx == `XDC_OFS_ACTL) ? {16'h0, actl_q} : 32'h0;

    // effective modes
    wire        ext_m    = cfg_q[`XDC_M_EXT - 1];
    wire        is_burst = cfg_q[`XDC_M_BURST - 1] & ~ext_m;
    wire        is_block = cfg_q[`XDC_M_BLOCK - 1] & ext_m;
    wire        word_m   = cfg_q[`XDC_M_DSIZE - 1];
    wire        giveup   = cfg_q[`XDC_M_GIVEUP - 1];
    wire        ie_m     = cfg_q[`XDC_M_IE - 1];
    wire [8:0]  blk_size = (cnt_q[23:16] == 8'h00) ? `XDC_BLK_FULL : {1'b0, cnt_q[23:16]};

    // transfer progress terms
    wire        rd_done  = ce_i & (st_q == XDC_RD) & mem_ready_i;
    wire        wr_done  = ce_i & (st_q == XDC_WR) & mem_ready_i;
    wire        busy     = in_unit_q | (st_q == XDC_RD) | (st_q == XDC_WR);
    wire        unit_last = ~is_block | (blk_left_q == 9'h001);
    wire        last_xfer = is_block ? (cnt_q[15:0] == 16'h0001) : (cnt_q == 24'h000001);
    wire        chan_end = last_xfer & unit_last;
    wire [24:0] src_nx   = adv(src_q, actl_q[`XDC_A_SMODE], actl_q[`XDC_A_SREP], word_m);
    wire [24:0] dst_nx   = adv(dst_q, actl_q[`XDC_A_DMODE], actl_q[`XDC_A_DREP], word_m);
    wire        ovf_s    = rd_done & src_nx[24] & actl_q[`XDC_A_SRIE];
    wire        ovf_d    = wr_done & dst_nx[24] & actl_q[`XDC_A_DRIE];
    wire        ovf_any  = ovf_q | ovf_d;
    wire        term     = chan_end | ovf_any | halt_q | ~en_q;
    wire        unit_end = wr_done & unit_last;
    wire        irq_set  = unit_end & ovf_any;
    wire        hw_clr   = (unit_end & (chan_end | ovf_any | halt_q)) | nmi_i;
    wire        req_in   = ext_m ? ext_req_i : 1'b1;
    wire        go       = en_q & ~other_bus_req_i & (in_unit_q | (~hi_chan_req_i & req_in));
    wire        start    = ce_i & (st_q == XDC_IDLE) & go & ~in_unit_q;

    // next state of the bus sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            XDC_IDLE: begin
                if (go) begin
                    st_d = XDC_RD;
                end
            end
            XDC_RD: begin
                if (mem_ready_i) begin
                    st_d = XDC_WR;
                end
            end
            XDC_WR: begin
                if (!mem_ready_i) begin
                    st_d = XDC_WR;
                end else if (unit_last & (term | ~is_burst)) begin
                    st_d = XDC_REL;
                end else if (nmi_i) begin
                    st_d = XDC_REL;
                end else if (giveup & other_bus_req_i) begin
                    st_d = XDC_REL;
                end else begin
                    st_d = XDC_RD;
                end
            end
            XDC_REL: st_d = XDC_IDLE;
            default: st_d = XDC_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q <= XDC_IDLE;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // address registers; a cpu write wins over the update
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            src_q <= `XDC_RST_ADDR;
            dst_q <= `XDC_RST_ADDR;
        end else begin
            if (wr_src) begin
                src_q <= 24'(mrg({8'h00, src_q}, avs_writedata_i, avs_byteenable_i));
            end else if (rd_done) begin
                src_q <= src_nx[23:0];
            end
            if (wr_dst) begin
                dst_q <= 24'(mrg({8'h00, dst_q}, avs_writedata_i, avs_byteenable_i));
            end else if (wr_done) begin
                dst_q <= dst_nx[23:0];
            end
        end
    end

    // transfer count: whole word in normal mode, low half per block in block mode
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= `XDC_RST_CNT;
        end else if (wr_cnt) begin
            cnt_q <= 24'(mrg({8'h00, cnt_q}, avs_writedata_i, avs_byteenable_i));
        end else if (wr_done & ~is_block & (cnt_q != 24'h000000)) begin
            cnt_q <= cnt_q - 24'h000001;
        end else if (unit_end & is_block & (cnt_q[15:0] != 16'h0000)) begin
            cnt_q[15:0] <= cnt_q[15:0] - 16'h0001;
        end
    end

    // configuration and address control
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cfg_q  <= `XDC_RST_CFG;
            actl_q <= `XDC_RST_ACTL;
        end else begin
            if (wr_mode) begin
                cfg_q <= mode_wv[`XDC_M_IE:`XDC_M_BURST];
            end
            if (wr_actl) begin
                actl_q <= 16'(mrg({16'h0, actl_q}, avs_writedata_i, avs_byteenable_i));
            end
        end
    end

    // enable, halt request and the two flags
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            en_q   <= 1'b0;
            halt_q <= 1'b0;
            flag_q <= 1'b0;
            berr_q <= 1'b0;
        end else if (ce_i) begin
            // a software set of enable wins over a hardware clear in the same cycle
            if (wr_mode & mode_wv[`XDC_M_EN]) begin
                en_q   <= 1'b1;
                halt_q <= 1'b0;
            end else if (hw_clr) begin
                en_q   <= 1'b0;
                halt_q <= 1'b0;
            end else if (wr_mode & en_q & busy) begin
                halt_q <= 1'b1;
            end else if (wr_mode) begin
                en_q   <= 1'b0;
            end
            // hardware set beats software clear
            if (irq_set) begin
                flag_q <= 1'b1;
            end else if (wr_mode & mode_wv[`XDC_M_EN] & ~en_q) begin
                flag_q <= 1'b0;
            end else if (wr_mode & ~mode_wv[`XDC_M_FLAG]) begin
                flag_q <= 1'b0;
            end
            if (nmi_i & in_unit_q & is_block) begin
                berr_q <= 1'b1;
            end else if (wr_mode & ~mode_wv[`XDC_M_BERR]) begin
                berr_q <= 1'b0;
            end
        end
    end

    // unit bookkeeping, deferred overflow, ack pulse and data hold
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            in_unit_q  <= 1'b0;
            blk_left_q <= 9'h000;
            ovf_q      <= 1'b0;
            ack_q      <= 1'b0;
            data_q     <= 16'h0000;
        end else if (ce_i) begin
            ack_q <= start & ext_m;
            if (start) begin
                in_unit_q  <= 1'b1;
                blk_left_q <= is_block ? blk_size : 9'h001;
            end else if (nmi_i | unit_end) begin
                in_unit_q  <= 1'b0;
            end else if (wr_done) begin
                blk_left_q <= blk_left_q - 9'h001;
            end
            if (unit_end | nmi_i) begin
                ovf_q <= 1'b0;
            end else if (ovf_s | ovf_d) begin
                ovf_q <= 1'b1;
            end
            if (rd_done) begin
                data_q <= mem_rdata_i;
            end
        end
    end

    // avalon read: snapshot taken in the wait cycle so all 24 bits belong together
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rdata_q   <= 32'h0;
            rd_done_q <= 1'b0;
        end else if (ce_i) begin
            rd_done_q <= avs_read_i & ~rd_done_q;
            if (avs_read_i & ~rd_done_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // outputs
    assign avs_waitrequest_o = avs_read_i & ~rd_done_q;
    assign avs_readdata_o    = rdata_q;
    assign req_ack_o         = ack_q;
    assign bus_own_o         = (st_q == XDC_RD) | (st_q == XDC_WR);
    assign xfer_end_o        = bus_own_o & (is_block ? (blk_left_q == 9'h001) : last_xfer);
    assign mem_rd_o          = (st_q == XDC_RD);
    assign mem_wr_o          = (st_q == XDC_WR);
    assign mem_addr_o        = mem_rd_o ? src_q : dst_q;
    assign mem_wdata_o       = data_q;
    assign irq_o             = flag_q & ie_m;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_cs_release;
        unit_end & ~is_burst |=> st_q == XDC_REL;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("no release after unit");
    property p_one_idle;
        ce_i & (st_q == XDC_REL) |=> (st_q == XDC_IDLE) & ~bus_own_o;
    endproperty
    a_one_idle: assert property (p_one_idle) else $error("release not one cycle");
    property p_burst_end;
        wr_done & is_burst & chan_end |=> ~bus_own_o;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("bus held after burst end");
    property p_ovf_term;
        irq_set & ~(wr_mode & mode_wv[`XDC_M_EN]) |=> flag_q & ~en_q;
    endproperty
    a_ovf_term: assert property (p_ovf_term) else $error("overflow did not terminate");
    property p_ack_once;
        start & ext_m |=> req_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("missing accept pulse");
    property p_blk_load;
        start & is_block |=> blk_left_q == $past(blk_size);
    endproperty
    a_blk_load: assert property (p_blk_load) else $error("block size not loaded");
    property p_src_hold;
        rd_done & ~actl_q[1] & ~wr_src |=> $stable(src_q);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("fixed source moved");
    property p_cnt_dec;
        wr_done & ~is_block & (cnt_q != 24'h0) & ~wr_cnt |=> cnt_q == $past(cnt_q) - 24'h1;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) else $error("count not decremented");
    property p_cnt_zero;
        wr_done & (cnt_q == 24'h0) & ~wr_cnt |=> cnt_q == 24'h0;
    endproperty
    a_cnt_zero: assert property (p_cnt_zero) else $error("zero count changed");
    property p_defer;
        wr_done & ~unit_last & ovf_d & ~nmi_i |=> en_q & ovf_q;
    endproperty
    a_defer: assert property (p_defer) else $error("overflow not deferred");
    property p_rd_ans;
        ce_i & avs_read_i & avs_waitrequest_o |=> ~avs_waitrequest_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    c_burst: cover property (wr_done & is_burst & ~unit_last | wr_done & is_burst & ~term);
    c_block: cover property (unit_end & is_block);
    c_ovf:   cover property (irq_set);
    c_give:  cover property (wr_done & giveup & other_bus_req_i & ~chan_end);
endmodule // xdc_channel

// ===== tb/xdc_mem_model.sv
// behavioural external memory answering the channel's read and write cycles
`timescale 1ns/100ps
module xdc_mem_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        slow_i,
    input  wire logic [23:0] mem_addr_i,
    input  wire logic        mem_rd_i,
    input  wire logic        mem_wr_i,
    output logic      [15:0] mem_rdata_o,
    output logic             mem_ready_o
);
    logic [15:0] last_q; // last datum driven
    logic [1:0]  wait_q; // stall cycles left for the next access
    // data is a pattern of the address; an idle bus shows the inverse of the last datum
    assign mem_rdata_o = mem_rd_i ? (mem_addr_i[15:0] ^ 16'h5a5a) : ~last_q;
    // one-cycle ready, after a random stall when slow, so the channel cannot count on timing
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            mem_ready_o <= 1'b0;
            wait_q      <= 2'h0;
            last_q      <= 16'h0000;
        end else if ((mem_rd_i || mem_wr_i) && !mem_ready_o) begin
            if (wait_q == 2'h0) begin
                mem_ready_o <= 1'b1;
                wait_q      <= slow_i ? 2'($urandom % 3) : 2'h0;
            end else begin
                wait_q <= wait_q - 2'h1;
            end
            if (mem_rd_i) last_q <= mem_rdata_o;
        end else begin
            mem_ready_o <= 1'b0;
        end
    end
endmodule // xdc_mem_model

// ===== tb/tb_top.sv
// self-checking bench for the external dma channel sequencer
`timescale 1ns/100ps
`include "xdc_map.svh"
module tb_top;
    localparam logic [4:0] A_SRC = {`XDC_OFS_SRC, 2'b00};
    localparam logic [4:0] A_DST = {`XDC_OFS_DST, 2'b00};
    localparam logic [4:0] A_CNT = {`XDC_OFS_CNT, 2'b00};
    localparam logic [4:0] A_MODE = {`XDC_OFS_MODE, 2'b00};
    localparam logic [4:0] A_ACTL = {`XDC_OFS_ACTL, 2'b00};
    logic        ref_clk_i, rst_b_i, avs_read, avs_write, ext_req, hi_req, nmi, slow, chk_on, end_q, own_q, obr;
    logic [4:0]  avs_addr;
    logic [31:0] avs_wdata, avs_readdata_o, q;
    logic        avs_waitrequest_o, req_ack_o, xfer_end_o, bus_own_o, mem_rd_o, mem_wr_o, mem_ready_i, irq_o;
    logic [23:0] mem_addr_o, s, d;
    logic [15:0] mem_wdata_o, mem_rdata_i;
    logic [63:0] exp_q[$];   // {src, dst, data mask} of each expected write
    logic [63:0] e;
    int          fails, compares, acks, ends, owns, n;
    xdc_channel u_xdc_channel (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .avs_address_i(avs_addr),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .ext_req_i(ext_req),
        .req_ack_o(req_ack_o), .xfer_end_o(xfer_end_o), .hi_chan_req_i(hi_req), .other_bus_req_i(obr),
        .nmi_i(nmi), .bus_own_o(bus_own_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ready_i(mem_ready_i), .irq_o(irq_o));
    xdc_mem_model u_xdc_mem_model (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
        .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_rdata_o(mem_rdata_i),
        .mem_ready_o(mem_ready_i));
    // free-running 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a used-up wait counts as a mismatch and closes the run
    task automatic hang();
        fails++;
        $display("BAD %0t wait ran out", $time);
        end_sim();
    endtask
    // avalon cycle: request held until the edge that sees waitrequest low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        @(posedge ref_clk_i);
        avs_addr  <= a;
        avs_wdata <= wd;
        if (rd) avs_read <= 1'b1;
        else avs_write <= 1'b1;
        k = 50;
        do begin
            @(posedge ref_clk_i);
            k--;
        end while (avs_waitrequest_o !== 1'b0 && k > 0);
        if (k == 0) hang();
        rdat = avs_readdata_o;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b0, a, wd, x);
    endtask
    // note the writes the channel must make, in order
    task automatic plan(input logic [23:0] ps, input logic [23:0] pd, input int ss, input int ds, input int k,
                        input logic [15:0] m);
        for (int i = 0; i < k; i++) begin
            exp_q.push_back({ps, pd, m});
            ps = ps + 24'(ss);
            pd = pd + 24'(ds);
        end
    endtask
    task automatic start(input logic [31:0] mode);
        acks = 0;
        ends = 0;
        owns = 0;
        reg_wr(A_MODE, mode);
    endtask
    // poll until the enable bit drops, then compare the counts and the registers
    task automatic finish(input int o, input int a, input int en, input logic [23:0] c, input logic [23:0] es,
                          input logic [23:0] ed);
        logic [31:0] x;
        int k;
        k = 300;
        do begin
            bus(1'b1, A_MODE, 32'h0, x);
            k--;
        end while (x[`XDC_M_EN] !== 1'b0 && k > 0);
        if (k == 0) hang();
        check(owns, o);
        if (a >= 0) check(acks, a);
        check(ends, en);
        bus(1'b1, A_CNT, 32'h0, x);
        check(x, c);
        bus(1'b1, A_SRC, 32'h0, x);
        check(x, es);
        bus(1'b1, A_DST, 32'h0, x);
        check(x, ed);
    endtask
    // watcher: counts strobes and bus grabs, compares each completed write with the oldest note
    always @(posedge ref_clk_i) begin
        if (req_ack_o === 1'b1) acks++;
        if (xfer_end_o === 1'b1 && end_q !== 1'b1) ends++;
        if (bus_own_o === 1'b1 && own_q !== 1'b1) owns++;
        end_q = xfer_end_o;
        own_q = bus_own_o;
        if (mem_wr_o === 1'b1 && mem_ready_i === 1'b1 && chk_on) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                check(mem_addr_o, e[39:16]);
                check(mem_wdata_o & e[15:0], (e[55:40] ^ 16'h5a5a) & e[15:0]);
            end
        end
    end
    initial begin
        {rst_b_i, avs_read, avs_write, ext_req, hi_req, nmi, slow, obr} = '0;
        {avs_addr, avs_wdata} = '0;
        chk_on = 1'b1;
        void'($urandom(95373));
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        // all registers clear after reset, unmapped place reads zero
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 5'(i * 4), 32'h0, q);
            check(q, 32'h0);
        end
        // auto cycle steal, word, random places; a higher channel holds off the start
        s = 24'($urandom) & 24'h7ffffe;
        d = 24'($urandom) & 24'h7ffffe;
        n = 1 + $urandom % 4;
        reg_wr(A_SRC, s);
        reg_wr(A_DST, d);
        reg_wr(A_CNT, n);
        reg_wr(A_ACTL, 32'h000a);
        plan(s, d, 2, 2, n, 16'hffff);
        hi_req <= 1'b1;
        start(32'h11);
        repeat (10) @(posedge ref_clk_i);
        check(owns, 0);
        hi_req <= 1'b0;
        finish(n, -1, 1, 24'h0, s + 24'(2 * n), d + 24'(2 * n));
        // auto burst, byte, destination counting down, slow memory
        slow <= 1'b1;
        reg_wr(A_SRC, 24'h001000);
        reg_wr(A_DST, 24'h002010);
        reg_wr(A_CNT, 4);
        reg_wr(A_ACTL, 32'h000e);
        plan(24'h001000, 24'h002010, 1, -1, 4, 16'h00ff);
        start(32'h03);
        finish(1, -1, 1, 24'h0, 24'h001004, 24'h00200c);
        // give-up bit: another master asks mid burst, takes the bus, and the burst resumes afterwards
        reg_wr(A_CNT, 4);
        reg_wr(A_ACTL, 32'h0000);
        plan(24'h001004, 24'h00200c, 0, 0, 4, 16'h00ff);
        start(32'h23);
        n = 200;
        while (mem_wr_o !== 1'b1 && n > 0) begin
            @(posedge ref_clk_i);
            n--;
        end
        obr <= 1'b1;
        // hold the other request until the channel has let go, so the yield cannot be missed
        while (bus_own_o !== 1'b0 && n > 0) begin
            @(posedge ref_clk_i);
            n--;
        end
        if (n == 0) hang();
        obr <= 1'b0;
        finish(2, -1, 1, 24'h0, 24'h001004, 24'h00200c);
        // external request with burst bit set still steals cycles, one ack per request
        ext_req <= 1'b1;
        reg_wr(A_CNT, 2);
        reg_wr(A_ACTL, 32'h000a);
        plan(24'h001004, 24'h00200c, 2, 2, 2, 16'hffff);
        start(32'h17);
        finish(2, 2, 1, 24'h0, 24'h001008, 24'h002010);
        // block mode: two blocks of three, source address keeps running, destination fixed, size byte untouched
        reg_wr(A_CNT, 32'h030002);
        reg_wr(A_ACTL, 32'h0002);
        plan(24'h001008, 24'h002010, 2, 0, 6, 16'hffff);
        start(32'h1d);
        finish(2, 2, 2, 24'h030000, 24'h001014, 24'h002010);
        ext_req <= 1'b0;
        // four-byte source repeat area with its interrupt: wrap, flag, stop, resume
        reg_wr(A_SRC, 24'h000102);
        reg_wr(A_DST, 24'h000200);
        reg_wr(A_CNT, 0);
        reg_wr(A_ACTL, 32'h4022);
        plan(24'h000102, 24'h000200, 2, 0, 1, 16'hffff);
        start(32'h51);
        finish(1, -1, 0, 24'h0, 24'h000100, 24'h000200);
        bus(1'b1, A_MODE, 32'h0, q);
        check(q, 32'h0d0);
        check(32'(irq_o), 32'h1);
        plan(24'h000100, 24'h000200, 2, 0, 2, 16'hffff);
        start(32'h51);
        finish(2, -1, 0, 24'h0, 24'h000100, 24'h000200);
        // non-maskable interrupt in mid block ends it with the block error flag
        chk_on = 1'b0;
        ext_req <= 1'b1;
        reg_wr(A_CNT, 32'h040001);
        start(32'h1d);
        n = 200;
        while (mem_wr_o !== 1'b1 && n > 0) begin
            @(posedge ref_clk_i);
            n--;
        end
        if (n == 0) hang();
        nmi <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        bus(1'b1, A_MODE, 32'h0, q);
        check(q & 32'h101, 32'h100);
        check(exp_q.size(), 0);
        end_sim();
    end
endmodule // tb_top
